/* rtl/spc_defines.vh */
// constants for the slave bus power and status controller
`ifndef SPC_DEFINES_VH
`define SPC_DEFINES_VH
// ==========================================
// timing
`define SPC_CLK_HZ 20000000
`define SPC_DEBOUNCE_MS 20
`define SPC_DEBOUNCE_CYC ((`SPC_CLK_HZ / 1000) * `SPC_DEBOUNCE_MS)
`define SPC_LOCKUP_US 10000
`define SPC_LOCKUP_CYC ((`SPC_CLK_HZ / 1000000) * `SPC_LOCKUP_US)
// ==========================================
// bus state codes reported to the host
`define SPC_CODE_OFF 2'h0
`define SPC_CODE_ON 2'h1
`define SPC_CODE_EXCESS 2'h2
`define SPC_CODE_BUSERR 2'h3
// ==========================================
// indicator colour codes {red, green}
`define SPC_LED_DARK 2'h0
`define SPC_LED_GREEN 2'h1
`define SPC_LED_RED 2'h2
`define SPC_MAX_SLAVES 8
`endif

/* rtl/spc_power_ctrl.v */
// slave bus power switching, over-current latch and front panel indicators
`timescale 1ns/1ps
`include "spc_defines.vh"
module spc_power_ctrl #(
   parameter DEBOUNCE_CYC = `SPC_DEBOUNCE_CYC,
   parameter LOCKUP_CYC = `SPC_LOCKUP_CYC,
   parameter CNT_W = 24
) (
   input wire i_sys_clk,
   input wire i_resetn,
   input wire i_button_n,
   input wire i_excess_current,
   input wire i_usb_vbus,
   input wire i_scl_in,
   input wire i_sda_in,
   input wire i_i2c_busy,
   input wire i_host_power_on,
   input wire i_host_power_off,
   output reg o_slave_power_en,
   output reg o_power_led_green,
   output reg o_power_led_red,
   output reg o_host_link_led_green,
   output reg o_bus_lockup_led_red,
   output reg [1:0] o_bus_state_code,
   output reg o_power_state,
   output reg o_excess_current_latched
);
   // ==========================================
   // pin synchronisation
   wire btn_n_s;
   wire oc_s;
   wire vbus_s;
   wire scl_s;
   wire sda_s;
   spc_sync_filter #(.RESET_VAL(1'b1)) u_btn (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_async(i_button_n),
      .o_level(btn_n_s)
   );
   spc_sync_filter #(.RESET_VAL(1'b0)) u_oc (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_async(i_excess_current),
      .o_level(oc_s)
   );
   spc_sync_filter #(.RESET_VAL(1'b0)) u_vbus (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_async(i_usb_vbus),
      .o_level(vbus_s)
   );
   spc_sync_filter #(.RESET_VAL(1'b1)) u_scl (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_async(i_scl_in),
      .o_level(scl_s)
   );
   spc_sync_filter #(.RESET_VAL(1'b1)) u_sda (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_async(i_sda_in),
      .o_level(sda_s)
   );
   // ==========================================
   // button debounce: level must hold for the whole window
   reg btn_stable_q;
   reg btn_prev_q;
   reg [CNT_W-1:0] db_cnt_q;
   wire press;
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         btn_stable_q <= 1'b0;
         btn_prev_q <= 1'b0;
         db_cnt_q <= {CNT_W{1'b0}};
      end else begin
         btn_prev_q <= btn_stable_q;
         if ((~btn_n_s) == btn_stable_q) begin
            db_cnt_q <= {CNT_W{1'b0}};
         end else if (db_cnt_q >= DEBOUNCE_CYC[CNT_W-1:0] - 1'b1) begin
            db_cnt_q <= {CNT_W{1'b0}};
            btn_stable_q <= ~btn_n_s;
         end else begin
            db_cnt_q <= db_cnt_q + 1'b1;
         end
      end
   end
   assign press = btn_stable_q & ~btn_prev_q;
   // ==========================================
   // power state machine
   localparam [2:0] ST_OFF = 3'h1;
   localparam [2:0] ST_ON = 3'h2;
   localparam [2:0] ST_FAULT = 3'h4;
   reg [2:0] state_q;
   reg [2:0] state_d;
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_OFF: begin
            // power only by operator or host command
            if ((press | i_host_power_on) & ~oc_s) begin
               state_d = ST_ON;
            end
         end
         ST_ON: begin
            if (oc_s) begin
               state_d = ST_FAULT;
            end else if (press | i_host_power_off) begin
               state_d = ST_OFF;
            end
         end
         ST_FAULT: begin
            // a press while the fault persists does nothing; the host cannot
            // clear the latch, so an operator must see the red lamp
            if (press & ~oc_s) begin
               state_d = ST_ON;
            end
         end
         default: begin
            state_d = ST_OFF;
         end
      endcase
   end
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q <= ST_OFF;
      end else begin
         state_q <= state_d;
      end
   end
   // ==========================================
   // I2C lockup watch: either line held low while no transfer runs
   reg [CNT_W-1:0] lk_cnt_q;
   reg lockup_q;
   wire lines_low;
   assign lines_low = (~scl_s | ~sda_s) & ~i_i2c_busy;
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         lk_cnt_q <= {CNT_W{1'b0}};
         lockup_q <= 1'b0;
      end else if (!lines_low || state_q != ST_ON) begin
         // unpowered slaves may pull the lines down; no fault then
         lk_cnt_q <= {CNT_W{1'b0}};
         lockup_q <= 1'b0;
      end else if (lk_cnt_q >= LOCKUP_CYC[CNT_W-1:0] - 1'b1) begin
         lockup_q <= 1'b1;
      end else begin
         lk_cnt_q <= lk_cnt_q + 1'b1;
      end
   end
   // ==========================================
   // registered outputs
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_slave_power_en <= 1'b0;
         o_power_led_green <= 1'b0;
         o_power_led_red <= 1'b0;
         o_host_link_led_green <= 1'b0;
         o_bus_lockup_led_red <= 1'b0;
         o_bus_state_code <= `SPC_CODE_OFF;
         o_power_state <= 1'b0;
         o_excess_current_latched <= 1'b0;
      end else begin
         // drop power the same cycle the fault is seen
         o_slave_power_en <= (state_d == ST_ON);
         o_power_led_green <= (state_d == ST_ON);
         o_power_led_red <= (state_d == ST_FAULT);
         o_host_link_led_green <= vbus_s;
         o_bus_lockup_led_red <= lockup_q;
         o_power_state <= (state_d == ST_ON);
         o_excess_current_latched <= (state_d == ST_FAULT);
         if (state_d == ST_FAULT) begin
            o_bus_state_code <= `SPC_CODE_EXCESS;
         end else if (state_d == ST_OFF) begin
            o_bus_state_code <= `SPC_CODE_OFF;
         end else if (lockup_q) begin
            o_bus_state_code <= `SPC_CODE_BUSERR;
         end else begin
            o_bus_state_code <= `SPC_CODE_ON;
         end
      end
   end
endmodule // spc_power_ctrl

/* rtl/spc_sync_filter.v */
// three-stage synchroniser with stable-level qualification
`timescale 1ns/1ps
module spc_sync_filter #(
   parameter RESET_VAL = 1'b0
) (
   input wire i_sys_clk,
   input wire i_resetn,
   input wire i_async,
   output reg o_level
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   // ==========================================
   // sync chain; first stage feeds only the second
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         s1_q <= RESET_VAL;
         s2_q <= RESET_VAL;
         s3_q <= RESET_VAL;
         o_level <= RESET_VAL;
      end else begin
         s1_q <= i_async;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            o_level <= s3_q;
         end
      end
   end
endmodule // spc_sync_filter

/* verification/spc_power_ctrl_chk.sv */
// checker for the slave bus power controller
`timescale 1ns/1ps
`include "spc_defines.vh"
module spc_power_ctrl_chk (
   input wire i_sys_clk,
   input wire i_resetn,
   input wire i_button_n,
   input wire i_excess_current,
   input wire i_usb_vbus,
   input wire i_host_power_on,
   input wire i_host_power_off,
   input wire o_slave_power_en,
   input wire o_power_led_green,
   input wire o_power_led_red,
   input wire o_host_link_led_green,
   input wire o_bus_lockup_led_red,
   input wire [1:0] o_bus_state_code,
   input wire o_excess_current_latched
);
   // ==========================================
   // runs of 5 to 8 cycles cover the input synchronisers
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   dark_off_a: assert property (!o_slave_power_en && !o_excess_current_latched |->
      !o_power_led_green && !o_power_led_red && o_bus_state_code == `SPC_CODE_OFF)
      else $error("dark");
   green_on_a: assert property (o_slave_power_en |-> o_power_led_green && !o_power_led_red)
      else $error("green");
   fault_red_a: assert property (o_excess_current_latched |-> o_power_led_red &&
      !o_power_led_green && !o_slave_power_en && o_bus_state_code == `SPC_CODE_EXCESS)
      else $error("red");
   excess_cut_a: assert property (i_excess_current[*5] |=> !o_slave_power_en)
      else $error("cut");
   host_on_a: assert property ((!i_excess_current)[*6] ##0
      (i_host_power_on && !o_excess_current_latched) |=>
      o_slave_power_en && o_bus_state_code == `SPC_CODE_ON) else $error("on");
   host_off_a: assert property (i_host_power_off && o_slave_power_en |=> !o_slave_power_en)
      else $error("off");
   fault_hold_a: assert property (i_button_n[*8] ##0 o_excess_current_latched
      |=> o_excess_current_latched) else $error("hold");
   link_led_a: assert property ($stable(i_usb_vbus)[*8] |->
      o_host_link_led_green == i_usb_vbus) else $error("link");
   cover property ($rose(o_excess_current_latched));
   cover property ($rose(o_bus_lockup_led_red));
   cover property ($rose(o_slave_power_en));
endmodule // spc_power_ctrl_chk
bind spc_power_ctrl spc_power_ctrl_chk i_spc_power_ctrl_chk (.*);

/* verification/spc_power_ctrl_tb.sv */
// self-checking bench for the slave bus power controller
`timescale 1ns/1ps
`include "spc_defines.vh"
`define CHK(n, e, s) num_checks++; if ((s) !== (e)) begin mismatches++; $display("BAD %s %h %h", n, e, s); end
module spc_power_ctrl_tb;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg btn_n = 1'b1;
   reg vbus = 1'b0;
   reg ovl = 1'b0;
   reg hold = 1'b0;
   reg p_on = 1'b0;
   reg p_off = 1'b0;
   reg busy = 1'b0;
   wire pst;
   reg [31:0] r;
   wire scl, sda, exc, en, grn, red, lnk, lck, lat;
   wire [1:0] code;
   integer seed = 37;
   integer mismatches = 0;
   integer num_checks = 0;
   integer k;
   spc_power_ctrl #(.DEBOUNCE_CYC(8), .LOCKUP_CYC(16)) i_spc_power_ctrl (.i_sys_clk(clk),
      .i_resetn(rst_n), .i_button_n(btn_n), .i_excess_current(exc), .i_usb_vbus(vbus),
      .i_scl_in(scl), .i_sda_in(sda), .i_i2c_busy(busy), .i_host_power_on(p_on),
      .i_host_power_off(p_off), .o_slave_power_en(en), .o_power_led_green(grn),
      .o_power_led_red(red), .o_host_link_led_green(lnk), .o_bus_lockup_led_red(lck),
      .o_bus_state_code(code), .o_power_state(pst), .o_excess_current_latched(lat));
   spc_slave_bus_model i_spc_slave_bus_model (.i_power_en(en), .i_overload(ovl),
      .i_hold_sda(hold), .o_scl(scl), .o_sda(sda), .o_excess_current(exc));
   initial forever #25 clk = ~clk;
   function [1:0] leds(input reg e, input reg l);
      leds = l ? `SPC_LED_RED : (e ? `SPC_LED_GREEN : `SPC_LED_DARK);
   endfunction
   task w(input integer n);
      repeat (n) @(negedge clk);
   endtask
   task st(input reg e, input reg [1:0] c, input reg l);
      begin
         `CHK("en", e, en)
         `CHK("pwr", e, pst)
         `CHK("code", c, code)
         `CHK("led", leds(e, l), {red, grn})
      end
   endtask
   // ==========================================
   // host pulses last one cycle; the press outlasts the shortened debounce
   task pulse(input reg on);
      begin
         @(posedge clk);
         if (on) p_on <= 1'b1;
         else p_off <= 1'b1;
         @(posedge clk);
         p_on <= 1'b0;
         p_off <= 1'b0;
         w(2);
      end
   endtask
   task press;
      begin
         @(posedge clk) btn_n <= 1'b0;
         w(30);
         @(posedge clk) btn_n <= 1'b1;
         w(30);
      end
   endtask
   task stop_test;
      begin
         $display("checks %0d mismatches %0d", num_checks, mismatches);
         if (mismatches == 0 && num_checks > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      mismatches++;
      stop_test;
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      w(2);
      st(0, `SPC_CODE_OFF, 0);
      pulse(1);
      st(1, `SPC_CODE_ON, 0);
      pulse(0);
      st(0, `SPC_CODE_OFF, 0);
      press;
      st(1, `SPC_CODE_ON, 0);
      press;
      st(0, `SPC_CODE_OFF, 0);
      pulse(1);
      @(posedge clk) ovl <= 1'b1;
      w(10);
      st(0, `SPC_CODE_EXCESS, 1);
      pulse(1);
      st(0, `SPC_CODE_EXCESS, 1);
      @(posedge clk) ovl <= 1'b0;
      press;
      `CHK("latch", 1'b0, lat)
      pulse(0);
      pulse(1);
      @(posedge clk) begin
         hold <= 1'b1;
         busy <= 1'b1;
      end
      w(40);
      `CHK("busy", 1'b0, lck)
      @(posedge clk) busy <= 1'b0;
      w(40);
      `CHK("lock", 2'h3, {lck, code == `SPC_CODE_BUSERR})
      @(posedge clk) hold <= 1'b0;
      w(12);
      `CHK("lock", 1'b0, lck)
      for (k = 0; k < 20; k++) begin
         r = $random(seed);
         @(posedge clk) vbus <= r[0];
         w(10);
         `CHK("link", vbus, lnk)
      end
      stop_test;
   end
endmodule // spc_power_ctrl_tb

/* verification/spc_slave_bus_model.sv */
// slave bus model: pulled-up i2c lines and a power-gated over-current flag
`timescale 1ns/1ps
module spc_slave_bus_model (
   input wire i_power_en,
   input wire i_overload,
   input wire i_hold_sda,
   output wire o_scl,
   output wire o_sda,
   output wire o_excess_current
);
   // ==========================================
   // unpowered slaves draw nothing, so the fault clears once power is cut
   assign o_excess_current = i_power_en & i_overload;
   // a hung slave holds data low; released lines sit at the pull-up
   assign o_scl = 1'b1;
   assign o_sda = ~(i_power_en & i_hold_sda);
endmodule // spc_slave_bus_model
